// ===== verilog/ref_cond_defines.svh
`ifndef REF_COND_DEFINES_SVH
`define REF_COND_DEFINES_SVH

// ==========================================================
// register byte offsets
`define OFS_MODE      8'h00
`define OFS_LOW_SP    8'h04
`define OFS_HIGH_SP   8'h08
`define OFS_LOSS_ACT  8'h0c
`define OFS_SW_SRC    8'h10
`define OFS_SLP_LVL   8'h14
`define OFS_SLP_TIME  8'h18
`define OFS_WAKE_LVL  8'h1c
`define OFS_WAKE_TIME 8'h20
`define OFS_MIN_FREQ  8'h24
`define OFS_MAX_FREQ  8'h28
`define OFS_PRESET0   8'h2c
`define OFS_CTRL      8'h30
`define OFS_STATUS    8'h34
`define OFS_FREQ_REF  8'h38

// ==========================================================
// reset values and limits (levels in 0.1 % of full scale)
`define RST_MODE      3'h2
`define RST_LOW_SP    11'h000
`define RST_HIGH_SP   11'h3e8
`define RST_LOSS_ACT  3'h0
`define RST_SW_SRC    3'h0
`define RST_SLP_LVL   11'h064
`define RST_WAKE_LVL  11'h096
`define RST_TIME      13'h0000
`define RST_MIN_FREQ  16'h0000
`define RST_MAX_FREQ  16'h1770
`define RST_PRESET0   16'h0000
`define LVL_FULL      11'h3e8
`define TIME_MAX      13'h1770

// ==========================================================
// loss thresholds: 1V/2mA and 1.5V/3mA are both 10 % and 15 %
`define LOSS_ON_LVL   11'h064
`define LOSS_OFF_LVL  11'h096
`define LIVE_ZERO     11'h0c8

// ==========================================================
// mode, loss action and sleep source codes
`define MODE_4_20     2'h1
`define MODE_BIPOLAR  2'h3
`define ACT_OFF       3'h0
`define ACT_FAULT     3'h1
`define ACT_STOP      3'h2
`define ACT_ZERO      3'h3
`define ACT_MIN       3'h4
`define ACT_MAX       3'h5
`define ACT_PRESET    3'h6
`define ACT_HOLD      3'h7
`define SRC_OFF       3'h0
`define SRC_AIN1      3'h1
`define SRC_AIN2      3'h2
`define SRC_CMD       3'h3
`define SRC_INDEP     3'h4

// ==========================================================
// timing: timer step 100 ms at a 100 MHz clock
`define STEP_TIME_MS  100
`define CLK_FREQ_MHZ  100

`endif

// ===== verilog/ref_cond_pkg.sv
package ref_cond_pkg;

  // ==========================================================
  // sleep state
  typedef enum logic {
    st_awake,
    st_asleep
  } sw_state_t;

  // ==========================================================
  // frequency limits and preset carried together
  typedef struct packed {
    logic [15:0] min_f;
    logic [15:0] max_f;
    logic [15:0] preset0;
  } freq_cfg_t;

endpackage : ref_cond_pkg

// ===== verilog/level_qual_timer.sv
`timescale 1ns/1ps
`include "ref_cond_defines.svh"

module level_qual_timer (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // qualification
  input  wire logic        cond_i,
  input  wire logic        step_i,
  input  wire logic [12:0] limit_i,
  output logic             done_o
);

  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  logic        reached;

  // ==========================================================
  // elapsed tenths of a second while the condition holds
  assign reached = (cnt_q >= limit_i);
  assign done_o  = cond_i && reached;
  assign cnt_d   = !cond_i ? `RST_TIME :
                   (step_i && !reached) ? cnt_q + 13'h0001 : cnt_q;

  // counter register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_q <= `RST_TIME;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : level_qual_timer

// ===== verilog/analog_ref_loss_sleep_wake.sv
`timescale 1ns/1ps
`include "ref_cond_defines.svh"

module analog_ref_loss_sleep_wake
  import ref_cond_pkg::*;
#(
  parameter int STEP_CYCLES = `STEP_TIME_MS * 1000 * `CLK_FREQ_MHZ
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // analog samples, 0.1 % of full scale
  input  wire logic signed [11:0] in2_sample_i,
  input  wire logic [10:0]        in1_level_i,
  input  wire logic [10:0]        cmd_freq_level_i,
  input  wire logic [10:0]        independent_sleep_source_i,
  input  wire logic [10:0]        independent_wake_source_i,
  // drive status and range switch pin
  input  wire logic               drive_running_i,
  input  wire logic               input_two_range_switch_i,
  // results
  output logic signed [16:0]      freq_ref_o,
  output logic                    loss_active_o,
  output logic                    analog_loss_fault_o,
  output logic                    stop_request_o,
  output logic [2:0]              stop_behaviour_o,
  output logic                    sleep_active_o,
  output logic                    run_flash_o
);

  // ==========================================================
  // settings
  logic [2:0]  in2_mode_select_q, in2_loss_action_q, sleep_wake_source_q;
  logic [10:0] in2_low_setpoint_q, in2_high_setpoint_q;
  logic [10:0] sleep_level_q, wake_level_q;
  logic [12:0] sleep_time_q, wake_time_q;
  logic [6:0]  ctrl_q;
  freq_cfg_t   fcfg_q;

  // bus decode
  logic        wr_en, hit;
  logic [10:0] wlvl;
  logic [12:0] wtime;
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign wlvl    = (pwdata > 32'(`LVL_FULL)) ? `LVL_FULL : pwdata[10:0];
  assign wtime   = (pwdata > 32'(`TIME_MAX)) ? `TIME_MAX : pwdata[12:0];
  assign hit     = (paddr <= `OFS_FREQ_REF) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !hit;

  // register writes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      in2_mode_select_q   <= `RST_MODE;
      in2_low_setpoint_q  <= `RST_LOW_SP;
      in2_high_setpoint_q <= `RST_HIGH_SP;
      in2_loss_action_q   <= `RST_LOSS_ACT;
      sleep_wake_source_q <= `RST_SW_SRC;
      sleep_level_q       <= `RST_SLP_LVL;
      sleep_time_q        <= `RST_TIME;
      wake_level_q        <= `RST_WAKE_LVL;
      wake_time_q         <= `RST_TIME;
      fcfg_q              <= {`RST_MIN_FREQ, `RST_MAX_FREQ, `RST_PRESET0};
      ctrl_q              <= 7'h00;
    end else if (wr_en) begin
      unique case (paddr)
        `OFS_MODE:      in2_mode_select_q   <= pwdata[2:0];
        `OFS_LOW_SP:    in2_low_setpoint_q  <= wlvl;
        `OFS_HIGH_SP:   in2_high_setpoint_q <= wlvl;
        `OFS_LOSS_ACT:  in2_loss_action_q   <= pwdata[2:0];
        `OFS_SW_SRC:    sleep_wake_source_q <= pwdata[2:0];
        `OFS_SLP_LVL:   sleep_level_q       <= wlvl;
        `OFS_SLP_TIME:  sleep_time_q        <= wtime;
        `OFS_WAKE_LVL:  wake_level_q        <= wlvl;
        `OFS_WAKE_TIME: wake_time_q         <= wtime;
        `OFS_MIN_FREQ:  fcfg_q.min_f        <= pwdata[15:0];
        `OFS_MAX_FREQ:  fcfg_q.max_f        <= pwdata[15:0];
        `OFS_PRESET0:   fcfg_q.preset0      <= pwdata[15:0];
        `OFS_CTRL:      ctrl_q              <= pwdata[6:0];
        default:        ;
      endcase
    end
  end

  // ==========================================================
  // range switch pin synchroniser
  logic sw_meta_q, sw_curr_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sw_meta_q <= 1'b0;
      sw_curr_q <= 1'b0;
    end else begin
      sw_meta_q <= input_two_range_switch_i;
      sw_curr_q <= sw_meta_q;
    end
  end

  // ==========================================================
  // scaling of input two
  function automatic logic [10:0] isqrt(input logic [20:0] v);
    logic [10:0] r;
    r = 11'h000;
    for (int b = 10; b >= 0; b--) begin
      if (({10'h000, r | (11'h001 << b)} * {10'h000, r | (11'h001 << b)})
          <= {1'b0, v}) begin
        r = r | (11'h001 << b);
      end
    end
    return r;
  endfunction : isqrt

  logic        inverted, is_current, bip_ok, neg;
  logic [11:0] abs_x;
  logic [10:0] mag, lin, norm, lo_v, hi_v, span, frac;
  logic [15:0] fspan;
  logic [27:0] uni_prod, bip_prod;
  logic [15:0] uni_f, bip_f;
  logic signed [16:0] calc_ref;

  assign inverted   = in2_low_setpoint_q > in2_high_setpoint_q;
  assign is_current = !in2_mode_select_q[1] || sw_curr_q;
  assign bip_ok     = (in2_mode_select_q[1:0] == `MODE_BIPOLAR) &&
                      !is_current &&
                      !inverted;
  assign abs_x = in2_sample_i[11] ? 12'(-in2_sample_i) : 12'(in2_sample_i);
  assign neg   = in2_sample_i[11] && bip_ok;
  // negative reads zero unless bipolar
  assign mag   = (in2_sample_i[11] && !bip_ok) ? 11'h000 :
                 (abs_x > 12'(`LVL_FULL)) ? `LVL_FULL : abs_x[10:0];
  assign lin   = (in2_mode_select_q[1:0] != `MODE_4_20) ? mag :
                 (mag < `LIVE_ZERO) ? 11'h000 :
                 11'((12'(mag - `LIVE_ZERO) * 12'h005) >> 2);
  assign norm  = in2_mode_select_q[2] ?
                 isqrt(21'(lin) * 21'(`LVL_FULL)) : lin;

  // unipolar: low maps to minimum, high to maximum
  assign lo_v  = inverted ? in2_high_setpoint_q : in2_low_setpoint_q;
  assign hi_v  = inverted ? in2_low_setpoint_q : in2_high_setpoint_q;
  assign span  = hi_v - lo_v;
  assign frac  = (norm <= lo_v) ? (inverted ? span : 11'h000) :
                 (norm >= hi_v) ? (inverted ? 11'h000 : span) :
                 (inverted ? hi_v - norm : norm - lo_v);
  assign fspan = (fcfg_q.max_f > fcfg_q.min_f) ?
                 fcfg_q.max_f - fcfg_q.min_f : 16'h0000;
  assign uni_prod = 28'(frac) * 28'(fspan);
  assign uni_f = (span == 11'h000) ? fcfg_q.min_f :
                 fcfg_q.min_f + 16'(uni_prod / 28'(span));
  // bipolar: minimum and low setpoint play no part
  assign bip_prod = 28'(norm) * 28'(fcfg_q.max_f);
  assign bip_f = (in2_high_setpoint_q == 11'h000 ||
                  norm >= in2_high_setpoint_q) ? fcfg_q.max_f :
                 16'(bip_prod / 28'(in2_high_setpoint_q));
  assign calc_ref = !bip_ok ? $signed({1'b0, uni_f}) :
                    neg ? -$signed({1'b0, bip_f}) : $signed({1'b0, bip_f});

  // ==========================================================
  // loss detection with hysteresis
  logic        loss_q, loss_d, is_fb, pid_fault;
  logic [10:0] loss_lvl;
  logic [2:0]  act;
  assign act      = in2_loss_action_q;
  assign loss_lvl = (abs_x > 12'(`LVL_FULL)) ? `LVL_FULL : abs_x[10:0];
  assign loss_d   = loss_q ? (loss_lvl < `LOSS_OFF_LVL)
                           : (loss_lvl < `LOSS_ON_LVL);
  assign is_fb     = ctrl_q[0];
  assign pid_fault = is_fb && (act != `ACT_OFF) &&
                     (ctrl_q[3:1] != 3'h0);
  assign stop_behaviour_o = ctrl_q[6:4];

  // ==========================================================
  // sleep and wake
  sw_state_t   sw_q, sw_d;
  logic [10:0] slp_src, wake_src;
  logic        sw_inv, slp_cond, wake_cond, slp_done, wake_done;
  logic        step, flash_q;
  logic [31:0] pre_q;
  assign slp_src = (sleep_wake_source_q == `SRC_AIN1) ? in1_level_i :
                   (sleep_wake_source_q == `SRC_AIN2) ? norm :
                   (sleep_wake_source_q == `SRC_CMD) ? cmd_freq_level_i :
                   independent_sleep_source_i;
  assign wake_src = (sleep_wake_source_q == `SRC_INDEP) ?
                    independent_wake_source_i : slp_src;
  assign sw_inv    = sleep_level_q > wake_level_q;
  assign slp_cond  = (sleep_wake_source_q != `SRC_OFF) && drive_running_i &&
                     (sw_inv ? slp_src > sleep_level_q
                             : slp_src < sleep_level_q);
  assign wake_cond = (sleep_wake_source_q != `SRC_OFF) &&
                     (sw_inv ? wake_src < wake_level_q
                             : wake_src > wake_level_q);
  assign step = (pre_q == 32'(STEP_CYCLES - 1));

  level_qual_timer u_sleep_timer (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i || sw_q == st_asleep),
    .cond_i    (slp_cond),
    .step_i    (step),
    .limit_i   (sleep_time_q),
    .done_o    (slp_done)
  );
  level_qual_timer u_wake_timer (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i || sw_q == st_awake),
    .cond_i    (wake_cond),
    .step_i    (step),
    .limit_i   (wake_time_q),
    .done_o    (wake_done)
  );

  // next sleep state
  always_comb begin
    sw_d = sw_q;
    unique case (sw_q)
      st_awake:  if (slp_done) sw_d = st_asleep;
      st_asleep: if (wake_done ||
                     sleep_wake_source_q == `SRC_OFF) sw_d = st_awake;
    endcase
  end

  // ==========================================================
  // reference selection
  logic signed [16:0] hold_q, ref_d, ref_q;
  logic               fault_q, stop_q;
  assign ref_d =
    (sw_d == st_asleep) ? 17'sh00000 :
    !loss_q ? calc_ref :
    (act == `ACT_ZERO) ? 17'sh00000 :
    (act == `ACT_MIN) ? $signed({1'b0, fcfg_q.min_f}) :
    (act == `ACT_MAX || (act == `ACT_OFF && inverted)) ?
      $signed({1'b0, fcfg_q.max_f}) :
    (act == `ACT_PRESET) ? $signed({1'b0, fcfg_q.preset0}) :
    (act == `ACT_HOLD) ? hold_q :
    (act == `ACT_OFF) ? calc_ref : 17'sh00000;

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      loss_q  <= 1'b0;
      sw_q    <= st_awake;
      hold_q  <= 17'sh00000;
      ref_q   <= 17'sh00000;
      fault_q <= 1'b0;
      stop_q  <= 1'b0;
      pre_q   <= 32'h0000_0000;
      flash_q <= 1'b0;
    end else begin
      loss_q  <= loss_d;
      sw_q    <= sw_d;
      hold_q  <= loss_d ? hold_q : calc_ref;
      ref_q   <= ref_d;
      fault_q <= loss_q && (act == `ACT_FAULT || pid_fault);
      stop_q  <= loss_q && (act == `ACT_STOP);
      pre_q   <= step ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      flash_q <= (sw_q == st_asleep) ? flash_q ^ step : 1'b0;
    end
  end

  assign freq_ref_o          = ref_q;
  assign loss_active_o       = loss_q;
  assign analog_loss_fault_o = fault_q;
  assign stop_request_o      = stop_q;
  assign sleep_active_o      = (sw_q == st_asleep);
  assign run_flash_o         = flash_q;

  // ==========================================================
  // read mux
  assign prdata =
    !(psel && hit) ? 32'h0000_0000 :
    (paddr == `OFS_MODE) ? 32'(in2_mode_select_q) :
    (paddr == `OFS_LOW_SP) ? 32'(in2_low_setpoint_q) :
    (paddr == `OFS_HIGH_SP) ? 32'(in2_high_setpoint_q) :
    (paddr == `OFS_LOSS_ACT) ? 32'(in2_loss_action_q) :
    (paddr == `OFS_SW_SRC) ? 32'(sleep_wake_source_q) :
    (paddr == `OFS_SLP_LVL) ? 32'(sleep_level_q) :
    (paddr == `OFS_SLP_TIME) ? 32'(sleep_time_q) :
    (paddr == `OFS_WAKE_LVL) ? 32'(wake_level_q) :
    (paddr == `OFS_WAKE_TIME) ? 32'(wake_time_q) :
    (paddr == `OFS_MIN_FREQ) ? 32'(fcfg_q.min_f) :
    (paddr == `OFS_MAX_FREQ) ? 32'(fcfg_q.max_f) :
    (paddr == `OFS_PRESET0) ? 32'(fcfg_q.preset0) :
    (paddr == `OFS_CTRL) ? 32'(ctrl_q) :
    (paddr == `OFS_STATUS) ?
      32'({sw_curr_q, flash_q, stop_q, fault_q, sw_q == st_asleep, loss_q}) :
    32'(unsigned'(ref_q));

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_lost_low;
    loss_lvl < `LOSS_ON_LVL ##1 loss_lvl < `LOSS_OFF_LVL;
  endsequence

  a_loss_entry: assert property (s_lost_low |=> loss_q)
    else $error("loss not declared below entry level");
  a_loss_exit: assert property (
    loss_q && loss_lvl >= `LOSS_OFF_LVL |=> !loss_q ##1 1)
    else $error("loss did not end at exit level");
  a_loss_hyst: assert property (
    loss_q && loss_lvl < `LOSS_OFF_LVL |=> loss_q)
    else $error("loss ended inside hysteresis band");
  a_fault_raise: assert property (
    loss_q && act == `ACT_FAULT |=> analog_loss_fault_o)
    else $error("fault not raised on loss");
  a_stop_raise: assert property (
    $rose(loss_q) && act == `ACT_STOP |=> stop_request_o)
    else $error("stop not requested on loss");
  a_max_on_loss: assert property (
    loss_q && act == `ACT_MAX && sw_d == st_awake
    |=> freq_ref_o == $signed({1'b0, $past(fcfg_q.max_f)}))
    else $error("max frequency not applied on loss");
  a_hold_last: assert property (
    $rose(loss_q) && act == `ACT_HOLD && sw_d == st_awake
    |=> freq_ref_o == $past(hold_q))
    else $error("held reference not applied");
  a_sleep_zero: assert property (sleep_active_o |-> freq_ref_o == 0)
    else $error("reference not zero while asleep");
  a_sleep_enter: assert property (
    sw_q == st_awake && slp_done |=> sleep_active_o)
    else $error("sleep not entered");
  a_wake_exit: assert property (
    sw_q == st_asleep && wake_done |=> !sleep_active_o)
    else $error("wake not taken");
  a_neg_bipolar: assert property (freq_ref_o < 0 |-> $past(bip_ok, 1))
    else $error("negative reference outside bipolar");

endmodule : analog_ref_loss_sleep_wake

// ===== verif/test_analog_ref_loss_sleep_wake.sv
`timescale 1ns/1ps

module test_analog_ref_loss_sleep_wake;
  // ==========================================================
  // signals
  logic               ref_clk_i, reset_i, psel, penable, pwrite;
  logic               pready, pslverr, err, loss, fault, stop, slp, run;
  logic               flash, fl0, rsw;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic signed [11:0] smp;
  logic signed [16:0] fref;
  logic [10:0]        cmd;
  logic [2:0]         sb;
  int                 n_fail, n_compared, k;

  typedef struct packed {logic [7:0] a; logic [31:0] v;} row_t;
  typedef struct packed {logic [2:0] a; logic [31:0] f; logic fl, st;} act_t;
  // register defaults after reset
  row_t rows [12] = '{'{8'h00, 32'h2}, '{8'h04, 32'h0}, '{8'h08, 32'h3e8},
    '{8'h0c, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h64}, '{8'h18, 32'h0},
    '{8'h1c, 32'h96}, '{8'h20, 32'h0}, '{8'h24, 32'h0},
    '{8'h28, 32'h1770}, '{8'h2c, 32'h0}};
  // loss action, reference, fault, stop while input is lost
  act_t acts [7] = '{'{3'h1, 32'd0, 1'b1, 1'b0},
    '{3'h2, 32'd0, 1'b0, 1'b1}, '{3'h3, 32'd0, 1'b0, 1'b0},
    '{3'h4, 32'd100, 1'b0, 1'b0}, '{3'h5, 32'd6000, 1'b0, 1'b0},
    '{3'h6, 32'd2500, 1'b0, 1'b0}, '{3'h7, 32'd3050, 1'b0, 1'b0}};

  analog_ref_loss_sleep_wake #(.STEP_CYCLES(10)) analog_ref_loss_sleep_wake_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in2_sample_i(smp), .in1_level_i(11'h000), .cmd_freq_level_i(cmd),
    .independent_sleep_source_i(11'h000),
    .independent_wake_source_i(11'h000), .drive_running_i(run),
    .input_two_range_switch_i(rsw), .freq_ref_o(fref),
    .loss_active_o(loss), .analog_loss_fault_o(fault),
    .stop_request_o(stop), .stop_behaviour_o(sb),
    .sleep_active_o(slp), .run_flash_o(flash));

  // ==========================================================
  // helpers
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask : apb

  task automatic settle;
    repeat (4) @(posedge ref_clk_i);
  endtask : settle

  task automatic wait_slp(input logic v);
    for (k = 0; k < 80 && slp !== v; k++) begin
      @(posedge ref_clk_i);
    end
    if (slp !== v) begin
      n_fail++;
      stop_test();
    end
  endtask : wait_slp

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, run, rsw, paddr, pwdata} = '0;
    smp = '0;
    cmd = '0;
    n_fail = 0;
    n_compared = 0;
    reset_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reset value", rows[i].v, rd);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, 8'h14, 32'h7ff);
    apb(1'b0, 8'h14, 32'h0);
    chk("level clamp", 32'h3e8, rd);
    apb(1'b1, 8'h14, 32'h64);
    smp <= 12'sd500;
    settle();
    chk("unipolar ref", 32'd3000, 32'(fref));
    apb(1'b0, 8'h38, 32'h0);
    chk("ref readback", 32'd3000, rd);
    // bipolar ignores minimum frequency and low setpoint
    apb(1'b1, 8'h24, 32'd100);
    apb(1'b1, 8'h04, 32'd100);
    apb(1'b1, 8'h00, 32'h3);
    smp <= -12'sd500;
    settle();
    chk("bipolar ref", -32'sd3000, 32'(fref));
    // current range pin forbids bipolar, negative reads zero
    rsw <= 1'b1;
    settle();
    chk("current blocks bipolar", 32'd100, 32'(fref));
    rsw <= 1'b0;
    apb(1'b1, 8'h00, 32'h1);
    smp <= 12'sd800;
    settle();
    chk("live zero ref", 32'd4361, 32'(fref));
    apb(1'b1, 8'h00, 32'h6);
    smp <= 12'sd250;
    settle();
    chk("root ref", 32'd2722, 32'(fref));
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h2c, 32'd2500);
    apb(1'b1, 8'h30, 32'h50);
    // each loss action except off (codes 1 to 7), restored then lost
    foreach (acts[i]) begin
      smp <= 12'sd500;
      apb(1'b1, 8'h0c, {29'h0, acts[i].a});
      settle();
      smp <= 12'sd50;
      settle();
      chk("loss ref", acts[i].f, 32'(fref));
      chk("loss fault", {31'h0, acts[i].fl}, {31'h0, fault});
      chk("loss stop", {31'h0, acts[i].st}, {31'h0, stop});
    end
    chk("stop mode", 32'h5, {29'h0, sb});
    apb(1'b1, 8'h30, 32'h53);
    settle();
    chk("feedback fault", 32'h1, {31'h0, fault});
    apb(1'b0, 8'h34, 32'h0);
    chk("status", 32'h5, rd);
    // inverted mapping, loss hysteresis
    apb(1'b1, 8'h30, 32'h50);
    apb(1'b1, 8'h0c, 32'h0);
    smp <= 12'sd500;
    apb(1'b1, 8'h04, 32'd800);
    apb(1'b1, 8'h08, 32'd200);
    settle();
    smp <= 12'sd50;
    settle();
    chk("inverted loss ref", 32'd6000, 32'(fref));
    chk("loss entry", 32'h1, {31'h0, loss});
    smp <= 12'sd120;
    settle();
    chk("loss hysteresis", 32'h1, {31'h0, loss});
    smp <= 12'sd150;
    settle();
    chk("loss exit", 32'h0, {31'h0, loss});
    // sleep on commanded frequency, then wake
    run <= 1'b1;
    cmd <= 11'd50;
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h20, 32'h3);
    apb(1'b1, 8'h10, 32'h3);
    repeat (5) @(posedge ref_clk_i);
    chk("sleep too early", 32'h0, {31'h0, slp});
    wait_slp(1'b1);
    settle();
    chk("asleep ref", 32'h0, 32'(fref));
    // run indicator toggles once per timer step while asleep
    fl0 = flash;
    repeat (10) @(posedge ref_clk_i);
    chk("run flash", {31'h0, !fl0}, {31'h0, flash});
    cmd <= 11'd200;
    repeat (5) @(posedge ref_clk_i);
    chk("wake too early", 32'h1, {31'h0, slp});
    wait_slp(1'b0);
    cmd <= 11'd50;
    wait_slp(1'b1);
    // reset in mid-run clears sleep and settings
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    chk("sleep after reset", 32'h0, {31'h0, slp});
    apb(1'b0, 8'h10, 32'h0);
    chk("source after reset", 32'h0, rd);
    stop_test();
  end
endmodule : test_analog_ref_loss_sleep_wake
